// [hw/maccs_params.svh]
// Behaviour
// - Single-product mode multiplies two signed 18-bit operands into a 36-bit product.
// - Dual mode adds two 9x9 cross products, scaled by two to the ninth.
// - Add mode result is product plus C plus D plus carry_input.
// - Two-operand forms use product with C or D; three-operand uses both.
// - Subtract mode result is C plus D plus carry_input minus product.
// - A, B, C, P and control registers are each bypassable.
// - Each register holds its value while its enable is low and both its clears are high.
// - cascade_in reaches the D selection with no register.
// - Result drives cascade_out; chains run left to right into cascade_in.
// - overflow_flag rises when the 44-bit add or subtract overflows.
// - With both selects low operand D is zero.
// - cascade_select high picks cascade_in, optionally shifted right arithmetically.
// - loopback_select alone picks the stored result register, optionally shifted.
// - shift17_enable shifts the chosen D operand right arithmetically by 17.
// - carry_input is the adder carry-in; C is a dynamic operand.
// - Upper clock serves upper halves, overflow and controls; lower serves lower halves. Here the single mclk clocks both.
// - Each half register has async clear, sync clear, enable and bypass.
`ifndef MACCS_PARAMS_SVH
`define MACCS_PARAMS_SVH

`define MACCS_W_AB    18
`define MACCS_W_HALF  9
`define MACCS_W_PROD  36
`define MACCS_W_P     44
`define MACCS_W_SUM   46
`define MACCS_P_SPLIT 18
`define MACCS_SHIFT   17
`define MACCS_DOT_EXP 9
`define MACCS_W_CTL   4

`endif

// [hw/maccs_pkg.sv]
package maccs_pkg;
   typedef logic [43:0] maccs_word_t;
   typedef enum logic [2:0] {
      MACCS_D_ZERO    = 3'b001,
      MACCS_D_CASCADE = 3'b010,
      MACCS_D_LOOP    = 3'b100
   } maccs_dsrc_e;
endpackage

// [hw/maccs_rctl_if.sv]
`timescale 1ns/1ps
interface maccs_rctl_if;
   logic arst_n;
   logic srst_n;
   logic en;
   logic bypass;
   modport source (output arst_n, output srst_n, output en, output bypass);
   modport sink   (input arst_n, input srst_n, input en, input bypass);
endinterface

// [hw/maccs_reg.sv]
`timescale 1ns/1ps
module maccs_reg #(
   parameter int W = 9
) (
   // Clock and global reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Register controls
   maccs_rctl_if.sink        ctl,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q_r,
   output logic      [W-1:0] dout
);
   logic clr_n;

   // The per-register clear is merged with the global reset; both only force zero.
   assign clr_n = rst_n & ctl.arst_n;

   always_ff @(posedge clk or negedge clr_n) begin
      if (!clr_n) begin
         q_r <= '0;
      end else if (!ctl.srst_n) begin
         q_r <= '0;
      end else if (ctl.en) begin
         q_r <= d;
      end
   end

   assign dout = ctl.bypass ? d : q_r;
endmodule

// [hw/maccs_slice.sv]
`timescale 1ns/1ps
`include "maccs_params.svh"
module maccs_slice (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Operand A, index 1 is the upper half
   input  wire logic [17:0] operand_a,
   input  wire logic [1:0]  operand_a_async_clear_n,
   input  wire logic [1:0]  operand_a_sync_clear_n,
   input  wire logic [1:0]  operand_a_enable,
   input  wire logic [1:0]  operand_a_bypass,
   // Operand B, index 1 is the upper half
   input  wire logic [17:0] operand_b,
   input  wire logic [1:0]  operand_b_async_clear_n,
   input  wire logic [1:0]  operand_b_sync_clear_n,
   input  wire logic [1:0]  operand_b_enable,
   input  wire logic [1:0]  operand_b_bypass,
   // Operand C
   input  wire logic [43:0] operand_c,
   input  wire logic        operand_c_async_clear_n,
   input  wire logic        operand_c_sync_clear_n,
   input  wire logic        operand_c_enable,
   input  wire logic        operand_c_bypass,
   // Control inputs and their register
   input  wire logic        cascade_select,
   input  wire logic        loopback_select,
   input  wire logic        shift17_enable,
   input  wire logic        subtract_select,
   input  wire logic        control_async_clear_n,
   input  wire logic        control_sync_clear_n,
   input  wire logic        control_enable,
   input  wire logic        control_bypass,
   // Static configuration and carry
   input  wire logic        dual_product_mode,
   input  wire logic        carry_input,
   // Cascade chain
   input  wire logic [43:0] cascade_in,
   output logic      [43:0] cascade_out,
   // Result register, index 1 is the upper half with overflow
   input  wire logic [1:0]  result_async_clear_n,
   input  wire logic [1:0]  result_sync_clear_n,
   input  wire logic [1:0]  result_enable,
   input  wire logic [1:0]  result_bypass,
   output logic      [43:0] result,
   output logic             overflow_flag
);
   localparam int WH = `MACCS_W_HALF;
   localparam int WP = `MACCS_W_P;
   localparam int SP = `MACCS_P_SPLIT;

   logic [`MACCS_W_AB-1:0]   a_v;
   logic [`MACCS_W_AB-1:0]   b_v;
   logic [WP-1:0]            c_v;
   logic [WP-1:0]            c_q;
   logic [`MACCS_W_CTL-1:0]  ctl_d;
   logic [`MACCS_W_CTL-1:0]  ctl_v;
   logic [`MACCS_W_CTL-1:0]  ctl_q;
   logic signed [35:0]       prod_norm;
   logic signed [17:0]       dot_p0;
   logic signed [17:0]       dot_p1;
   logic signed [18:0]       dot_sum;
   logic [WP-1:0]            prod_ext;
   logic [WP-1:0]            d_sel;
   logic [WP-1:0]            d_base;
   logic [WP-1:0]            p_stored;
   logic [`MACCS_W_SUM-1:0]  sum_w;
   logic [WP-1:0]            sum_p;
   logic                     ovf_nxt;
   logic [WP-SP:0]           p_hi_d;
   logic [WP-SP:0]           p_hi_q;
   logic [WP-SP:0]           p_hi_v;
   logic [SP-1:0]            p_lo_q;
   logic [SP-1:0]            p_lo_v;
   maccs_pkg::maccs_dsrc_e   d_src;

   //************************************************************
   // Operand half registers
   //************************************************************
   // Both halves run on mclk, so the upper and lower clocks are the same net.
   for (genvar h = 0; h < 2; h++) begin : g_half
      maccs_rctl_if ia ();
      maccs_rctl_if ib ();
      assign ia.arst_n = operand_a_async_clear_n[h];
      assign ia.srst_n = operand_a_sync_clear_n[h];
      assign ia.en     = operand_a_enable[h];
      assign ia.bypass = operand_a_bypass[h];
      assign ib.arst_n = operand_b_async_clear_n[h];
      assign ib.srst_n = operand_b_sync_clear_n[h];
      assign ib.en     = operand_b_enable[h];
      assign ib.bypass = operand_b_bypass[h];

      maccs_reg #(.W(WH)) u_a (
         .clk   (mclk),
         .rst_n (rst_n),
         .ctl   (ia),
         .d     (operand_a[h*WH +: WH]),
         .q_r   (),
         .dout  (a_v[h*WH +: WH])
      );
      maccs_reg #(.W(WH)) u_b (
         .clk   (mclk),
         .rst_n (rst_n),
         .ctl   (ib),
         .d     (operand_b[h*WH +: WH]),
         .q_r   (),
         .dout  (b_v[h*WH +: WH])
      );
   end

   //************************************************************
   // Operand C and control registers
   //************************************************************
   maccs_rctl_if ic ();
   maccs_rctl_if ik ();
   assign ic.arst_n = operand_c_async_clear_n;
   assign ic.srst_n = operand_c_sync_clear_n;
   assign ic.en     = operand_c_enable;
   assign ic.bypass = operand_c_bypass;
   assign ik.arst_n = control_async_clear_n;
   assign ik.srst_n = control_sync_clear_n;
   assign ik.en     = control_enable;
   assign ik.bypass = control_bypass;
   assign ctl_d     = {subtract_select, shift17_enable, loopback_select, cascade_select};

   maccs_reg #(.W(WP)) u_c (
      .clk   (mclk),
      .rst_n (rst_n),
      .ctl   (ic),
      .d     (operand_c),
      .q_r   (c_q),
      .dout  (c_v)
   );
   maccs_reg #(.W(`MACCS_W_CTL)) u_ctl (
      .clk   (mclk),
      .rst_n (rst_n),
      .ctl   (ik),
      .d     (ctl_d),
      .q_r   (ctl_q),
      .dout  (ctl_v)
   );

   //************************************************************
   // Multiplier
   //************************************************************
   assign prod_norm = $signed(a_v) * $signed(b_v);
   assign dot_p0    = $signed(a_v[WH-1:0]) * $signed(b_v[2*WH-1:WH]);
   assign dot_p1    = $signed(a_v[2*WH-1:WH]) * $signed(b_v[WH-1:0]);
   assign dot_sum   = {dot_p0[17], dot_p0} + {dot_p1[17], dot_p1};

   // The mode input is static; changing it mid-stream mixes the two formats.
   assign prod_ext = dual_product_mode ?
                     {{16{dot_sum[18]}}, dot_sum, 9'h000} :
                     {{8{prod_norm[35]}}, prod_norm};

   //************************************************************
   // Operand D selection
   //************************************************************
   // Loopback reads the stored result so a bypassed result cannot form a loop.
   assign p_stored = {p_hi_q[WP-SP-1:0], p_lo_q};

   always_comb begin
      if (ctl_v[0]) begin
         d_src = maccs_pkg::MACCS_D_CASCADE;
      end else if (ctl_v[1]) begin
         d_src = maccs_pkg::MACCS_D_LOOP;
      end else begin
         d_src = maccs_pkg::MACCS_D_ZERO;
      end
   end

   always_comb begin
      case (d_src)
         maccs_pkg::MACCS_D_CASCADE: begin
            d_base = cascade_in;
         end
         maccs_pkg::MACCS_D_LOOP: begin
            d_base = p_stored;
         end
         default: begin
            d_base = '0;
         end
      endcase
      if (ctl_v[2] && d_src != maccs_pkg::MACCS_D_ZERO) begin
         d_sel = {{`MACCS_SHIFT{d_base[WP-1]}}, d_base[WP-1:`MACCS_SHIFT]};
      end else begin
         d_sel = d_base;
      end
   end

   //************************************************************
   // Adder and subtractor
   //************************************************************
   // Two guard bits make every overflow visible in the top three sum bits.
   always_comb begin
      if (ctl_v[3]) begin
         sum_w = {{2{c_v[WP-1]}}, c_v} + {{2{d_sel[WP-1]}}, d_sel}
               + {45'h0, carry_input} - {{2{prod_ext[WP-1]}}, prod_ext};
      end else begin
         sum_w = {{2{prod_ext[WP-1]}}, prod_ext} + {{2{c_v[WP-1]}}, c_v}
               + {{2{d_sel[WP-1]}}, d_sel} + {45'h0, carry_input};
      end
   end

   assign sum_p   = sum_w[WP-1:0];
   assign ovf_nxt = !((&sum_w[45:43]) || !(|sum_w[45:43]));

   //************************************************************
   // Result registers
   //************************************************************
   maccs_rctl_if iph ();
   maccs_rctl_if ipl ();
   assign iph.arst_n = result_async_clear_n[1];
   assign iph.srst_n = result_sync_clear_n[1];
   assign iph.en     = result_enable[1];
   assign iph.bypass = result_bypass[1];
   assign ipl.arst_n = result_async_clear_n[0];
   assign ipl.srst_n = result_sync_clear_n[0];
   assign ipl.en     = result_enable[0];
   assign ipl.bypass = result_bypass[0];
   assign p_hi_d     = {ovf_nxt, sum_p[WP-1:SP]};

   maccs_reg #(.W(WP-SP+1)) u_p_hi (
      .clk   (mclk),
      .rst_n (rst_n),
      .ctl   (iph),
      .d     (p_hi_d),
      .q_r   (p_hi_q),
      .dout  (p_hi_v)
   );
   maccs_reg #(.W(SP)) u_p_lo (
      .clk   (mclk),
      .rst_n (rst_n),
      .ctl   (ipl),
      .d     (sum_p[SP-1:0]),
      .q_r   (p_lo_q),
      .dout  (p_lo_v)
   );

   // Result bit 43 with overflow_flag lets outside logic saturate.
   assign result        = {p_hi_v[WP-SP-1:0], p_lo_v};
   assign overflow_flag = p_hi_v[WP-SP];
   assign cascade_out   = result;

   //************************************************************
   // Checks
   //************************************************************
   normal_product_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !dual_product_mode |-> $signed(prod_ext) == $signed(a_v) * $signed(b_v))
      else $error("normal product wrong");

   dual_product_a: assert property (@(posedge mclk) disable iff (!rst_n)
      dual_product_mode |-> prod_ext[8:0] == 9'h000 &&
      $signed(prod_ext[43:9]) == $signed(dot_p0) + $signed(dot_p1))
      else $error("dual product wrong");

   add_sum_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !ctl_v[3] |-> sum_p == 44'(prod_ext + c_v + d_sel + {43'h0, carry_input}))
      else $error("add result wrong");

   sub_diff_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ctl_v[3] |-> sum_p == 44'(c_v + d_sel + {43'h0, carry_input} - prod_ext))
      else $error("subtract result wrong");

   dsel_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !ctl_v[0] && !ctl_v[1] |-> d_sel == 44'h0)
      else $error("operand d not zero");

   dsel_cascade_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ctl_v[0] |-> d_sel == (ctl_v[2] ? 44'($signed(cascade_in) >>> 17) : cascade_in))
      else $error("operand d not cascade");

   dsel_loop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !ctl_v[0] && ctl_v[1] |-> d_sel == (ctl_v[2] ? 44'($signed(p_stored) >>> 17) : p_stored))
      else $error("operand d not loopback");

   p_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
      result_enable[1] && result_sync_clear_n[1] && result_async_clear_n[1] &&
      !result_bypass[1] ##1 result_async_clear_n[1] && !result_bypass[1]
      |-> result[43:18] == $past(sum_p[43:18]) && overflow_flag == $past(ovf_nxt))
      else $error("result upper half not loaded");

   p_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !result_enable[0] && result_sync_clear_n[0] && result_async_clear_n[0]
      ##1 result_async_clear_n[0] |-> $stable(p_lo_q))
      else $error("result lower half did not hold");

   sync_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !control_sync_clear_n && control_enable ##1 control_async_clear_n |-> ctl_q == 4'h0)
      else $error("sync clear lost to enable");

   ovf_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ovf_nxt == ($signed(sum_w) > 46'sh7ff_ffff_ffff || $signed(sum_w) < -46'sh800_0000_0000))
      else $error("overflow flag wrong");

   cascade_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cascade_out == {p_hi_v[25:0], p_lo_v})
      else $error("cascade out differs from result");

   c_bypass_a: assert property (@(posedge mclk) disable iff (!rst_n)
      operand_c_bypass |-> c_v == operand_c)
      else $error("operand c bypass broken");
endmodule

// [bench/maccs_nbr.sv]
`timescale 1ns/1ps
module maccs_nbr (
   // Clock
   input  wire logic        mclk,
   // Upstream slice word
   input  wire logic        load,
   input  wire logic [43:0] word,
   output logic      [43:0] cascade_word,
   // Result seen by fabric saturation logic
   input  wire logic [43:0] result,
   input  wire logic        overflow_flag,
   output logic      [43:0] sat_result
);
   // The chain register lives in the fabric, since the slice has none on its input.
   always_ff @(posedge mclk) begin
      if (load) begin
         cascade_word <= word;
      end
   end

   // An overflowed result has the wrong sign, so its bit 43 picks the opposite limit.
   always_comb begin
      if (!overflow_flag) begin
         sat_result = result;
      end else if (result[43]) begin
         sat_result = 44'h7ff_ffff_ffff;
      end else begin
         sat_result = 44'h800_0000_0000;
      end
   end
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin num_errors++; \
   $display("FAIL %s expected %h seen %h", nm, ex, gt); end end
module tb;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [17:0] a = '0, b = '0;
   logic [43:0] c = '0, nbr_word = '0;
   logic [43:0] cascade_word, result, cascade_out, sat_result;
   logic        overflow_flag;
   logic [1:0]  a_aclr = 2'h3, ab_sclr = 2'h3, ab_en = 2'h3, ab_byp = 2'h3;
   logic [1:0]  r_sclr = 2'h3, r_en = 2'h3, r_byp = 2'h3;
   logic        c_sclr = 1'b1, c_en = 1'b1, c_byp = 1'b1, ctl_en = 1'b1, ctl_byp = 1'b1;
   logic        cs = 1'b0, lb = 1'b0, sh = 1'b0, sub = 1'b0, dual = 1'b0, cin = 1'b0;
   logic        ctl_sclr = 1'b1;
   int          num_errors = 0;
   int          n_compared = 0;

   always #12.5 mclk = ~mclk;

   maccs_slice i_maccs_slice (
      .mclk(mclk), .rst_n(rst_n),
      .operand_a(a), .operand_a_async_clear_n(a_aclr), .operand_a_sync_clear_n(ab_sclr),
      .operand_a_enable(ab_en), .operand_a_bypass(ab_byp),
      .operand_b(b), .operand_b_async_clear_n(2'h3), .operand_b_sync_clear_n(ab_sclr),
      .operand_b_enable(ab_en), .operand_b_bypass(ab_byp),
      .operand_c(c), .operand_c_async_clear_n(1'b1), .operand_c_sync_clear_n(c_sclr),
      .operand_c_enable(c_en), .operand_c_bypass(c_byp),
      .cascade_select(cs), .loopback_select(lb), .shift17_enable(sh), .subtract_select(sub),
      .control_async_clear_n(1'b1), .control_sync_clear_n(ctl_sclr),
      .control_enable(ctl_en), .control_bypass(ctl_byp),
      .dual_product_mode(dual), .carry_input(cin),
      .cascade_in(cascade_word), .cascade_out(cascade_out),
      .result_async_clear_n(2'h3), .result_sync_clear_n(r_sclr),
      .result_enable(r_en), .result_bypass(r_byp),
      .result(result), .overflow_flag(overflow_flag));

   maccs_nbr i_maccs_nbr (
      .mclk(mclk), .load(1'b1), .word(nbr_word), .cascade_word(cascade_word),
      .result(result), .overflow_flag(overflow_flag), .sat_result(sat_result));

   // ****************************************
   // Reference arithmetic and checks
   // ****************************************
   function automatic logic [45:0] f_sum(input logic [17:0] fa, fb, input logic [43:0] fc, fd,
                                         input logic fci, fsub, fdual);
      logic signed [45:0] p;
      if (fdual) begin
         p = ($signed(fa[8:0]) * $signed(fb[17:9]) + $signed(fa[17:9]) * $signed(fb[8:0]))
             * 46'sd512;
      end else begin
         p = $signed(fa) * $signed(fb);
      end
      if (fsub) begin
         f_sum = $signed(fc) + $signed(fd) + $signed({1'b0, fci}) - p;
      end else begin
         f_sum = p + $signed(fc) + $signed(fd) + $signed({1'b0, fci});
      end
   endfunction

   task automatic chk_out(input string nm, input logic [45:0] s);
      logic ovf;
      ovf = (s[45:43] != 3'b000) && (s[45:43] != 3'b111);
      `CHK(nm, s[43:0], result)
      `CHK(nm, s[43:0], cascade_out)
      `CHK(nm, ovf, overflow_flag)
   endtask

   // Everything bypassed: the answer is combinational within the cycle.
   task automatic run_c(input string nm, input logic [17:0] ia, ib, input logic [43:0] ic, iw,
                        input logic [3:0] ictl, input logic idual, icin);
      logic [43:0] d;
      @(posedge mclk);
      nbr_word <= iw;
      @(posedge mclk);
      a <= ia;
      b <= ib;
      c <= ic;
      {cs, lb, sh, sub} <= ictl;
      dual <= idual;
      cin <= icin;
      @(negedge mclk);
      d = ictl[3] ? (ictl[1] ? 44'($signed(iw) >>> 17) : iw) : 44'h0;
      chk_out(nm, f_sum(ia, ib, ic, d, icin, ictl[0], idual));
   endtask

   task automatic t_comb;
      run_c("mul_neg", 18'h20000, 18'h3ffff, 44'h0, 44'h0, 4'b0000, 1'b0, 1'b0);
      run_c("mul_max", 18'h20000, 18'h20000, 44'h0, 44'h0, 4'b0000, 1'b0, 1'b0);
      run_c("add_c", 18'h3, 18'h3fffb, 44'h1000, 44'h5, 4'b0000, 1'b0, 1'b1);
      run_c("add_cd", 18'h7, 18'h9, 44'h100, 44'hfff_ffff_0000, 4'b1000, 1'b0, 1'b1);
      run_c("cas_lb", 18'h7, 18'h9, 44'h0, 44'h123_4567, 4'b1100, 1'b0, 1'b0);
      run_c("sub", 18'h1f, 18'h3ffe0, 44'h50, 44'h77, 4'b1001, 1'b0, 1'b1);
      run_c("shift", 18'h1, 18'h1, 44'h0, 44'h800_0012_3456, 4'b1010, 1'b0, 1'b0);
      run_c("zero_d", 18'h1, 18'h1, 44'h0, 44'h123, 4'b0010, 1'b0, 1'b0);
      run_c("dual", 18'h3fe03, 18'h00bfe, 44'h0, 44'h0, 4'b0000, 1'b1, 1'b0);
      run_c("ovf_pos", 18'h1, 18'h1, 44'h7ff_ffff_ffff, 44'h0, 4'b0000, 1'b0, 1'b0);
      `CHK("sat_pos", 44'h7ff_ffff_ffff, sat_result)
      run_c("ovf_neg", 18'h3ffff, 18'h1, 44'h800_0000_0000, 44'h0, 4'b0000, 1'b0, 1'b0);
      `CHK("sat_neg", 44'h800_0000_0000, sat_result)
      $display("test comb done");
   endtask

   // All registers in use: clears, latency, hold and a per-half async clear.
   task automatic t_pipe;
      @(posedge mclk);
      {ab_byp, c_byp, ctl_byp, r_byp} <= '0;
      {cs, lb, sh, sub, dual, cin} <= '0;
      a <= 18'd3;
      b <= 18'd5;
      c <= 44'd7;
      {ab_sclr, c_sclr, r_sclr} <= '0;
      @(posedge mclk);
      {ab_sclr, c_sclr, r_sclr} <= 5'h1f;
      @(negedge mclk);
      `CHK("sclr", 44'h0, result)
      @(posedge mclk);
      @(negedge mclk);
      `CHK("lat1", 44'h0, result)
      @(posedge mclk);
      ab_en <= 2'h0;
      a <= 18'd100;
      @(negedge mclk);
      `CHK("lat2", 44'd22, result)
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      `CHK("hold", 44'd22, result)
      @(posedge mclk);
      a_aclr <= 2'b10;
      @(posedge mclk);
      a_aclr <= 2'h3;
      ab_en <= 2'h3;
      @(negedge mclk);
      `CHK("aclr", 44'd7, result)
      // Result hold, then a control sync clear that must beat the enabled load of sub.
      @(posedge mclk);
      r_en <= 2'h0;
      ctl_sclr <= 1'b0;
      sub <= 1'b1;
      @(posedge mclk);
      r_en <= 2'h3;
      ctl_sclr <= 1'b1;
      @(negedge mclk);
      `CHK("r_hold", 44'd7, result)
      @(posedge mclk);
      @(negedge mclk);
      `CHK("ctl_sclr", 44'd507, result)
      @(posedge mclk);
      @(negedge mclk);
      `CHK("sub_reg", 44'hfff_ffff_fe13, result)
      `CHK("ovf_reg", 1'b0, overflow_flag)
      $display("test pipe done");
   endtask

   // Loopback accumulates the stored result, then adds it shifted.
   task automatic t_loop;
      @(posedge mclk);
      {ab_byp, c_byp, ctl_byp, r_byp} <= 6'h3c;
      a <= 18'd2;
      b <= 18'd3;
      c <= 44'hfff_fffc_0000;
      {cs, lb, sh, sub} <= 4'b0100;
      r_sclr <= 2'h0;
      @(posedge mclk);
      r_sclr <= 2'h3;
      @(posedge mclk);
      c <= 44'h0;
      @(negedge mclk);
      `CHK("loop1", 44'hfff_fffc_0006, result)
      @(posedge mclk);
      sh <= 1'b1;
      @(negedge mclk);
      `CHK("loop2", 44'hfff_fffc_000c, result)
      @(posedge mclk);
      @(negedge mclk);
      `CHK("loop_sh", 44'h4, result)
      $display("test loop done");
   endtask

   task automatic tally_and_finish;
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      t_comb;
      t_pipe;
      t_loop;
      tally_and_finish;
   end

   initial begin
      #(2000 * 25);
      num_errors++;
      $display("Watchdog expired before the tests ended");
      tally_and_finish;
   end
endmodule
